// file: rtl/srod_pkg.sv
/*
 * Constants for the supply reset and oscillator default block: register
 * offsets, field positions, reset values and the release delay.
 * Assumes a 16-bit register port addressed by word offset.
 */
package srod_pkg;

    // Register offsets, as word addresses on the register port.
    localparam logic [15:0] BROWNOUT_CONFIG_OFS      = 16'h0985;
    localparam logic [15:0] CLOCK_SOURCE_CONTROL_OFS = 16'h7012;
    localparam logic [15:0] OSC_ONE_TRIM_OFS         = 16'h7014;
    localparam logic [15:0] OSC_TWO_TRIM_OFS         = 16'h7016;

    // Field positions in brownout_config.
    localparam int BOR_OFF_BIT      = 0;
    localparam int STAT_FAULT_BIT   = 8;
    localparam int STAT_STRAP_BIT   = 9;
    localparam int STAT_HOLD_BIT    = 10;
    localparam int STAT_POWERED_BIT = 11;

    // Field positions in clock_source_control.
    localparam int OSC_ONE_OFF_BIT = 0;
    localparam int OSC_TWO_OFF_BIT = 1;
    localparam int CLK_SRC_BIT     = 2;

    // Reset values.
    localparam logic       BOR_OFF_RST    = 1'b0;
    localparam logic [2:0] CLK_CTL_RST    = 3'h0;
    localparam logic [15:0] TRIM_RST      = 16'h0000;
    localparam logic [15:0] RDATA_RST     = 16'h0000;

    // Reset release delay after the last supply fault clears.
    localparam int CLK_PERIOD_PS    = 5000;
    localparam int RELEASE_DELAY_NS = 1000;
    localparam int RELEASE_CYCLES   =
        (RELEASE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

endpackage : srod_pkg

// file: rtl/srod_release_timer.sv
/*
 * Stretches a supply fault into a reset hold that outlasts the fault
 * by a fixed number of cycles.
 * Assumes the fault input is synchronous to the clock.
 */
`timescale 1ns/1ps
module srod_release_timer #(
    parameter int CYCLES = srod_pkg::RELEASE_CYCLES
) (
    // Clock and reset
    input  wire logic mclk,
    input  wire logic resetn,
    // Fault in, hold out
    input  wire logic fault,
    output logic      hold
);
    import srod_pkg::*;

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);

    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic          hold_ff;

    // Any fault cycle reloads the full delay.
    assign nxt_cnt = fault ? LOAD
                   : (cnt_ff != '0) ? cnt_ff - 1'b1 : '0;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff  <= LOAD;
            hold_ff <= 1'b1;
        end else begin
            cnt_ff  <= nxt_cnt;
            hold_ff <= (nxt_cnt != '0);
        end
    end

    assign hold = hold_ff;

endmodule // srod_release_timer

// file: rtl/srod_top.sv
/*
 * Supply reset generation and internal oscillator defaults.
 * Assumes supply monitor comparator outputs and the strap are synchronous
 * to mclk, and that the open-drain reset wire is resolved outside.
 */
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module srod_top #(
    parameter int          RELEASE_CYC = srod_pkg::RELEASE_CYCLES,
    parameter logic [15:0] TRIM1_RST   = srod_pkg::TRIM_RST,
    parameter logic [15:0] TRIM2_RST   = srod_pkg::TRIM_RST
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        resetn,
    // Register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [15:0] reg_rdata,
    input  wire logic        protected_write_enable,
    // Supply monitor comparators and the regulator strap, high while the condition holds
    input  wire logic        core_por_low,
    input  wire logic        io_por_low,
    input  wire logic        core_bor_low,
    input  wire logic        io_bor_low,
    input  wire logic        core_ov_high,
    input  wire logic        regulator_disable_strap,
    // Other reset sources
    input  wire logic        watchdog_reset,
    // Open-drain external reset pin
    input  wire logic        external_reset_n_in,
    output logic             external_reset_n_out,
    output logic             external_reset_n_oe,
    // Device reset and monitor reset
    output logic             supply_monitor_reset,
    output logic             device_reset_n,
    // Oscillator controls
    output logic             osc_one_enable,
    output logic             osc_two_enable,
    output logic             clock_source_sel,
    output logic      [15:0] osc_one_trim_val,
    output logic      [15:0] osc_two_trim_val,
    // Clock pass-through
    input  wire logic        cpu_clock_in,
    output logic             system_clock_out
);
    import srod_pkg::*;

    // Register state.
    logic        bor_off_ff;
    logic [2:0]  clk_ctl_ff;
    logic [15:0] trim1_ff;
    logic [15:0] trim2_ff;
    logic [15:0] rdata_ff;

    // Strap capture and power-up state.
    logic        strap_ff;
    logic        strap_taken_ff;
    logic        powered_ff;

    // Output flops.
    logic        dev_rst_n_ff;
    logic        sysclk_ff;

    // Decode.
    wire hit_bor  = (reg_addr == BROWNOUT_CONFIG_OFS);
    wire hit_clk  = (reg_addr == CLOCK_SOURCE_CONTROL_OFS);
    wire hit_t1   = (reg_addr == OSC_ONE_TRIM_OFS);
    wire hit_t2   = (reg_addr == OSC_TWO_TRIM_OFS);
    wire wr_ok    = reg_wr && protected_write_enable;
    wire wr_bor   = wr_ok && hit_bor;
    wire wr_clk   = wr_ok && hit_clk;
    wire wr_t1    = wr_ok && hit_t1;
    wire wr_t2    = wr_ok && hit_t2;

    // Until the strap is captured, assume the regulator is on so the core
    // brownout and overvoltage checks err on the safe side.
    wire reg_on   = !(strap_taken_ff && strap_ff);

    // Supply fault terms.
    wire por_flt  = core_por_low || io_por_low;
    wire io_bor   = powered_ff && !bor_off_ff && io_bor_low;
    wire core_bor = powered_ff && !bor_off_ff && reg_on
                    && core_bor_low;
    wire ov_flt   = reg_on && core_ov_high;
    wire fault    = por_flt || io_bor || core_bor || ov_flt;

    wire hold;

    // Fault is stretched by the release delay.
    srod_release_timer #(
        .CYCLES (RELEASE_CYC)
    ) u_release (
        .mclk   (mclk),
        .resetn (resetn),
        .fault  (fault),
        .hold   (hold)
    );

    // Read mux; unmapped addresses read as zero.
    wire [15:0] bor_rd = {4'h0,
                          powered_ff, hold, strap_ff, fault,
                          7'h00, bor_off_ff};
    wire [15:0] clk_rd = {13'h0000, clk_ctl_ff};
    wire [15:0] rd_sel = hit_bor ? bor_rd
                       : hit_clk ? clk_rd
                       : hit_t1  ? trim1_ff
                       : hit_t2  ? trim2_ff
                       : 16'h0000;

    // The external reset pin reads low while anything drives it.
    wire nxt_dev_rst_n = !(hold || watchdog_reset
                           || !external_reset_n_in);

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            bor_off_ff <= BOR_OFF_RST;
            clk_ctl_ff <= CLK_CTL_RST;
            trim1_ff   <= TRIM1_RST;
            trim2_ff   <= TRIM2_RST;
        end else begin
            if (wr_bor) begin
                bor_off_ff <= reg_wdata[BOR_OFF_BIT];
            end
            if (wr_clk) begin
                clk_ctl_ff <= reg_wdata[2:0];
            end
            if (wr_t1) begin
                trim1_ff <= reg_wdata;
            end
            if (wr_t2) begin
                trim2_ff <= reg_wdata;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= RDATA_RST;
        end else begin
            rdata_ff <= reg_rd ? rd_sel : RDATA_RST;
        end
    end

    // The strap is caught at the first edge after release, never under
    // the asynchronous reset itself.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            strap_ff       <= 1'b0;
            strap_taken_ff <= 1'b0;
        end else if (!strap_taken_ff) begin
            strap_ff       <= regulator_disable_strap;
            strap_taken_ff <= 1'b1;
        end
    end

    // Brownout only counts once the first power-up release is done.
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            powered_ff <= 1'b0;
        end else if (!hold) begin
            powered_ff <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            dev_rst_n_ff <= 1'b0;
            sysclk_ff    <= 1'b0;
        end else begin
            dev_rst_n_ff <= nxt_dev_rst_n;
            sysclk_ff    <= cpu_clock_in;
        end
    end

    // Output assignments; each comes from a flop, the oscillator enables inverted, except external_reset_n_out, which is tied low.
    assign reg_rdata            = rdata_ff;
    assign external_reset_n_out = 1'b0;
    assign external_reset_n_oe  = hold;
    assign supply_monitor_reset = hold;
    assign device_reset_n       = dev_rst_n_ff;
    assign osc_one_enable       = !clk_ctl_ff[OSC_ONE_OFF_BIT];
    assign osc_two_enable       = !clk_ctl_ff[OSC_TWO_OFF_BIT];
    assign clock_source_sel     = clk_ctl_ff[CLK_SRC_BIT];
    assign osc_one_trim_val     = trim1_ff;
    assign osc_two_trim_val     = trim2_ff;
    assign system_clock_out     = sysclk_ff;

    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    // Counts quiet cycles since the last fault, saturating.
    logic [15:0] quiet_cnt;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            quiet_cnt <= 16'h0000;
        end else if (fault) begin
            quiet_cnt <= 16'h0000;
        end else if (quiet_cnt != 16'hffff) begin
            quiet_cnt <= quiet_cnt + 16'h0001;
        end
    end

    a_por_always: assert property (
        (core_por_low || io_por_low) |=> external_reset_n_oe)
        else $error("power-on low did not hold reset");

    a_core_bor_gate: assert property (
        (core_bor_low && !io_bor_low && !por_flt && !core_ov_high
         && strap_taken_ff && strap_ff) |-> !fault)
        else $error("core brownout counted with regulator off");

    a_fault_holds: assert property (
        fault |=> external_reset_n_oe && supply_monitor_reset)
        else $error("fault did not assert external reset");

    a_ov_regulated: assert property (
        (core_ov_high && reg_on) |=> external_reset_n_oe)
        else $error("overvoltage with regulator did not hold reset");

    a_bor_disable: assert property (
        (bor_off_ff && !por_flt && !ov_flt) |-> !fault)
        else $error("brownout acted while disabled");

    a_osc_default: assert property (
        $rose(resetn) |-> osc_one_enable && osc_two_enable
                          && !clock_source_sel)
        else $error("oscillator defaults wrong after reset");

    a_trim_write: assert property (
        wr_t1 |=> osc_one_trim_val == $past(reg_wdata))
        else $error("trim one write not applied");

    a_write_locked: assert property (
        (reg_wr && !protected_write_enable)
        |=> $stable(clk_ctl_ff) && $stable(trim1_ff)
            && $stable(trim2_ff) && $stable(bor_off_ff))
        else $error("protected register changed without enable");

    a_clock_pass: assert property (
        ##1 system_clock_out == $past(cpu_clock_in))
        else $error("system clock does not follow cpu clock");

    a_watchdog_rst: assert property (
        watchdog_reset |=> !device_reset_n)
        else $error("watchdog did not reset device");

    a_release_delay: assert property (
        $fell(external_reset_n_oe) |-> quiet_cnt == 16'(RELEASE_CYC))
        else $error("reset released at wrong delay");

    a_hold_quiet: assert property (
        (quiet_cnt >= 16'(RELEASE_CYC)) |-> !hold)
        else $error("reset held past the release delay");

    a_hold_short: assert property (
        (quiet_cnt != 16'h0000 && quiet_cnt < 16'(RELEASE_CYC)) |-> hold)
        else $error("reset released before the delay ran out");

    a_io_bor_count: assert property (
        (powered_ff && !bor_off_ff && io_bor_low) |=> external_reset_n_oe)
        else $error("io brownout did not hold reset");

    a_powered_sticky: assert property (
        powered_ff |=> powered_ff)
        else $error("power-up state was lost");

    a_strap_stable: assert property (
        strap_taken_ff |=> $stable(strap_ff))
        else $error("captured strap changed");

    a_ov_unregulated: assert property (
        (core_ov_high && !reg_on && !core_bor_low && !io_bor_low
         && !por_flt) |-> !fault)
        else $error("overvoltage counted with regulator off");

    a_bor_readback: assert property (
        (reg_rd && hit_bor) |=> reg_rdata[BOR_OFF_BIT] == $past(bor_off_ff))
        else $error("brownout disable bit read back wrong");

    a_osc_select: assert property (
        wr_clk |=> (osc_one_enable == !$past(reg_wdata[OSC_ONE_OFF_BIT]))
                   && (osc_two_enable == !$past(reg_wdata[OSC_TWO_OFF_BIT])))
        else $error("oscillator enables not applied");

    a_trim_two_write: assert property (
        wr_t2 |=> osc_two_trim_val == $past(reg_wdata))
        else $error("trim two write not applied");

    a_trim_read: assert property (
        (reg_rd && hit_t1) |=> reg_rdata == $past(trim1_ff))
        else $error("trim one read back wrong");

    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == RDATA_RST)
        else $error("read data not idle without a read");

    a_ext_wire_rst: assert property (
        !external_reset_n_in |=> !device_reset_n)
        else $error("low reset wire did not reset device");

    // Covers show that each main path is reached: release after a fault,
    // an oscillator powered down, a refused write, an overvoltage trip and
    // a core brownout seen while the strap turns the regulator off.
    c_fault_release: cover property (
        fault ##1 !fault ##[1:1000] !external_reset_n_oe);

    c_osc_off: cover property (wr_clk ##1 !osc_two_enable);

    c_locked_write: cover property (reg_wr && !protected_write_enable);

    c_ov_trip: cover property (ov_flt && !por_flt);

    c_strap_off: cover property (strap_taken_ff && strap_ff && core_bor_low);

endmodule // srod_top

// file: verification/srod_board.sv
/*
 * Board model: the supply rails, the regulator strap and the external
 * reset wire with its pull-up.
 * Assumes the bench sets rail faults and board reset off the clock edge.
 */
`timescale 1ns/1ps
module srod_board (
    // Requests from the bench
    input  wire logic [4:0] rail_faults,
    input  wire logic       strap_high,
    input  wire logic       board_reset,
    // Device side
    input  wire logic       ext_out,
    input  wire logic       ext_oe,
    output logic      [4:0] comparators,
    output logic            strap_pin,
    output logic            ext_wire
);
    assign comparators = rail_faults;
    // The strap is fixed by the board wiring.
    assign strap_pin   = strap_high;
    // The pull-up wins unless the device or the board pulls the wire low.
    assign ext_wire    = ((ext_oe && !ext_out) || board_reset) ? 1'b0 : 1'b1;
endmodule // srod_board

// file: verification/tb.sv
/*
 * Self-checking bench for srod_top with a board model on the supply side.
 * Assumes a short release delay so that every fault scenario stays brief.
 */
`timescale 1ns/1ps
module tb;
    import srod_pkg::*;
    localparam int RC = 4;
    logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, prot = 0;
    logic [15:0] reg_addr = '0, reg_wdata = '0, reg_rdata, rv, t1, t2;
    logic [4:0]  faults = '0, cmp;
    logic strap = 0, wd = 0, brst = 0, cpu = 0, r, bor_off = 0;
    logic spin, ext_in, ext_out, oe, smr, dev_n, o1, o2, sel, sysclk;
    logic [15:0] tr1, tr2;
    int n_mismatch = 0, comparisons = 0;

    srod_board board (.rail_faults(faults), .strap_high(strap),
        .board_reset(brst), .ext_out(ext_out), .ext_oe(oe),
        .comparators(cmp), .strap_pin(spin), .ext_wire(ext_in));
    srod_top #(.RELEASE_CYC(RC)) dut (.mclk(mclk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .protected_write_enable(prot), .io_por_low(cmp[0]),
        .core_por_low(cmp[1]), .io_bor_low(cmp[2]), .core_bor_low(cmp[3]),
        .core_ov_high(cmp[4]), .regulator_disable_strap(spin),
        .watchdog_reset(wd), .external_reset_n_in(ext_in),
        .external_reset_n_out(ext_out), .external_reset_n_oe(oe),
        .supply_monitor_reset(smr), .device_reset_n(dev_n),
        .osc_one_enable(o1), .osc_two_enable(o2), .clock_source_sel(sel),
        .osc_one_trim_val(tr1), .osc_two_trim_val(tr2),
        .cpu_clock_in(cpu), .system_clock_out(sysclk));

    initial begin
        forever #2.5 mclk = ~mclk;
    end

    task automatic conclude();
        $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Bit order of f: io_por, core_por, io_bor, core_bor, core_ov.
    function automatic logic exp_hold(input logic [4:0] f);
        return f[0] | f[1] | (f[2] & !bor_off) |
               ((f[3] & !bor_off | f[4]) & !strap);
    endfunction

    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input logic p);
        @(posedge mclk);
        reg_addr <= a; reg_wdata <= d; prot <= p; reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic fault_check(input logic [4:0] f);
        logic e;
        e = exp_hold(f);
        @(posedge mclk) faults <= f;
        repeat (3) @(posedge mclk);
        #1 chk({15'h0, oe}, {15'h0, e});
        chk({15'h0, smr}, {15'h0, e});
        chk({15'h0, dev_n}, {15'h0, !e});
        @(posedge mclk) faults <= '0;
        repeat (RC - 1) @(posedge mclk);
        #1 chk({15'h0, oe}, {15'h0, e});
        repeat (4) @(posedge mclk);
        #1 chk({15'h0, oe}, 16'h0);
    endtask

    task automatic do_reset(input logic s);
        @(posedge mclk);
        resetn <= 1'b0; strap <= s; bor_off = 1'b0;
        repeat (8) @(posedge mclk);
        resetn <= 1'b1;
        repeat (RC + 6) @(posedge mclk);
    endtask

    initial begin
        #100000;
        n_mismatch++;
        conclude();
    end

    initial begin
        void'($urandom(32'h426a));
        repeat (8) @(posedge mclk);
        #1 chk({13'h0, o1, o2, sel}, 16'h0006);
        chk(tr1 | tr2, 16'h0);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk({15'h0, oe}, 16'h1);
        repeat (RC + 4) @(posedge mclk);
        #1 chk({15'h0, oe}, 16'h0);
        chk({15'h0, dev_n}, 16'h1);
        wr(CLOCK_SOURCE_CONTROL_OFS, 16'h0007, 1'b0);
        chk({13'h0, o1, o2, sel}, 16'h0006);
        for (int v = 0; v < 8; v++) begin
            wr(CLOCK_SOURCE_CONTROL_OFS, 16'(v), 1'b1);
            chk({13'h0, o1, o2, sel}, {13'h0, ~v[0], ~v[1], v[2]});
            rd(CLOCK_SOURCE_CONTROL_OFS, rv);
            chk(rv & 16'h0007, 16'(v));
        end
        t1 = 16'($urandom);
        t2 = 16'($urandom);
        wr(OSC_ONE_TRIM_OFS, t1, 1'b1);
        wr(OSC_TWO_TRIM_OFS, t2, 1'b1);
        wr(OSC_ONE_TRIM_OFS, ~t1, 1'b0);
        chk(tr1, t1);
        chk(tr2, t2);
        rd(OSC_TWO_TRIM_OFS, rv);
        chk(rv, t2);
        rd(16'h7015, rv);
        chk(rv, 16'h0);
        wr(CLOCK_SOURCE_CONTROL_OFS, 16'h0000, 1'b1);
        for (int i = 0; i < 5; i++) fault_check(5'h1 << i);
        wr(BROWNOUT_CONFIG_OFS, 16'h0001, 1'b1);
        bor_off = 1'b1;
        rd(BROWNOUT_CONFIG_OFS, rv);
        chk(rv & 16'h0001, 16'h0001);
        for (int i = 0; i < 5; i++) fault_check(5'h1 << i);
        fault_check(5'h0c);
        @(posedge mclk) wd <= 1'b1;
        @(posedge mclk) wd <= 1'b0;
        #1 chk({15'h0, dev_n}, 16'h0);
        @(posedge mclk) brst <= 1'b1;
        @(posedge mclk) brst <= 1'b0;
        #1 chk({15'h0, dev_n}, 16'h0);
        repeat (20) begin
            r = 1'($urandom);
            @(posedge mclk) cpu <= r;
            @(posedge mclk);
            #1 chk({15'h0, sysclk}, {15'h0, r});
        end
        // Park the CPU clock low so the pass-through check stays quiet
        // across the next reset, where the output is forced low.
        @(posedge mclk) cpu <= 1'b0;
        @(posedge mclk);
        do_reset(1'b1);
        for (int i = 0; i < 5; i++) fault_check(5'h1 << i);
        fault_check(5'h18);
        do_reset(1'b0);
        fault_check(5'h18);
        conclude();
    end
endmodule // tb
